/* File: src/cchyst_top.sv */
// comparator control top: wishbone registers, analog steering, hysteresis and interrupt
//
// Functional notes
// RULE1: positive input chosen by input-select bits 3..2: lvd, pb0, pb3, 1v2.
// RULE2: negative input chosen by bits 1..0: lvd, pb0, pb3, ladder node.
// RULE3: input-short bit set closes switch joining both comparator inputs.
// RULE4: 32-position node selector driven by effective 5-bit node select.
// RULE5: ladder top source from main bits 7..6: none, supply, regulator, bias.
// RULE6: input-select bit 7 returns low section to ground or analog ground.
// RULE7: bit 6 shorts 22.5R section, bit 5 shorts 20R section.
// RULE8: masked node-select bits follow comparator output, others keep value.
// RULE9: software sets output inversion whenever hysteresis mask is used.
// RULE10: read-only main bit 5 shows comparator result.
// RULE11: main bit 3 inverts the comparator digital output.
// RULE12: main bit 2 routes output through 2 us glitch filter.
// RULE13: main bit 1 selects low-power or normal-speed mode.
// RULE14: enable bit 0 clear disables comparator and forces result to 0.
// RULE15: rising edge of comparator output sets interrupt flag.
// RULE16: flag sets again only on a fresh rising edge.
// RULE17: four control registers at 7A..7D reset to zero.
// RULE18: raw comparator output is synchronised by two flops first.
// RULE19: writing one clears the flag; a same-cycle set wins.
`timescale 1ns/1ps
`default_nettype none
module cchyst_top #(
    parameter int FILTER_CYCLES = cchyst_pkg::CCH_FILTER_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // analog comparator interface
    input  wire logic        comparator_out_signal,
    output logic             comparator_enable,
    output logic             speed_mode_select,
    output logic             input_short_switch,
    output logic [1:0]       positive_input_select,
    output logic [1:0]       negative_input_select,
    output logic [1:0]       ladder_source_select,
    output logic [2:0]       ladder_low_section_control,
    output logic [31:0]      ladder_node_onehot,
    output logic [4:0]       ladder_node_effective,
    output logic             comparator_result,
    output logic             irq
);
    import cchyst_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] main_ctrl_r;
    logic [7:0] input_sel_r;
    logic [CCH_NODE_W-1:0] ladder_node_select_r;
    logic [CCH_NODE_W-1:0] hysteresis_mask_r;
    logic       comparator_interrupt_flag_r;
    logic       irq_mask_r;

    logic       req;
    logic       wr_stb;
    logic       cmp_sync;
    logic       cmp_filt;
    logic       cmp_sel;
    logic       result_nxt;
    logic       result_prev_r;
    logic       rise;
    logic [31:0] rd_word;

    // full byte compare: neighbouring control registers share a word and must not alias
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction

    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = req && wb_we_i && wb_sel_i[0];

    // ------------------------------------------------------------
    // wishbone slave: one wait state, ack for one cycle
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // control registers; bit 5 of main control is status and ignores writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_ctrl_r          <= CCH_MAIN_CTRL_RST; // [RULE17]
            input_sel_r          <= CCH_INPUT_SEL_RST; // [RULE17]
            ladder_node_select_r <= CCH_NODE_SEL_RST[CCH_NODE_W-1:0]; // [RULE17]
            hysteresis_mask_r    <= CCH_HYST_MASK_RST[CCH_NODE_W-1:0]; // [RULE17]
        end else if (wr_stb) begin
            if (hit(wb_adr_i, CCH_MAIN_CTRL_OFS)) begin
                main_ctrl_r <= wb_dat_i[7:0] & ~(8'h01 << CCH_MC_RESULT);
            end
            if (hit(wb_adr_i, CCH_INPUT_SEL_OFS)) begin
                input_sel_r <= wb_dat_i[7:0] & 8'hEF;
            end
            if (hit(wb_adr_i, CCH_NODE_SEL_OFS)) begin
                ladder_node_select_r <= wb_dat_i[CCH_NODE_W-1:0];
            end
            if (hit(wb_adr_i, CCH_HYST_MASK_OFS)) begin
                hysteresis_mask_r <= wb_dat_i[CCH_NODE_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_mask_r <= 1'b0;
        end else if (wr_stb && hit(wb_adr_i, CCH_IRQ_MASK_OFS)) begin
            irq_mask_r <= wb_dat_i[CCH_IRQ_BIT];
        end
    end

    // ------------------------------------------------------------
    // analog steering outputs
    // ------------------------------------------------------------
    assign comparator_enable          = main_ctrl_r[CCH_MC_ENABLE]; // [RULE14]
    assign speed_mode_select          = main_ctrl_r[CCH_MC_SPEED]; // [RULE13]
    assign input_short_switch         = main_ctrl_r[CCH_MC_SHORT]; // [RULE3]
    assign ladder_source_select       = main_ctrl_r[CCH_MC_SRC_LSB +: 2]; // [RULE5]
    assign positive_input_select      = input_sel_r[CCH_IS_POS_LSB +: 2]; // [RULE1]
    assign negative_input_select      = input_sel_r[CCH_IS_NEG_LSB +: 2]; // [RULE2]
    // bit 2 ground return, bit 1 short 22.5R, bit 0 short 20R
    assign ladder_low_section_control = {input_sel_r[CCH_IS_GND_RET], // [RULE6]
                                         input_sel_r[CCH_IS_SHORT_HI], // [RULE7]
                                         input_sel_r[CCH_IS_SHORT_LO]}; // [RULE7]

    // ------------------------------------------------------------
    // comparator output path
    // ------------------------------------------------------------
    cchyst_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (comparator_out_signal),
        .sync_out (cmp_sync)
    ); // [RULE18]

    cchyst_filter #(
        .HOLD_CYCLES (FILTER_CYCLES)
    ) u_filter (
        .core_clk (core_clk),
        .rst      (rst),
        .din      (cmp_sync),
        .dout     (cmp_filt)
    );

    // filter always runs so enabling it mid-stream needs no warm-up
    assign cmp_sel    = main_ctrl_r[CCH_MC_FILTER] ? cmp_filt : cmp_sync; // [RULE12]
    assign result_nxt = main_ctrl_r[CCH_MC_ENABLE] &
                        (cmp_sel ^ main_ctrl_r[CCH_MC_INVERT]); // [RULE11] [RULE14]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            comparator_result <= 1'b0;
            result_prev_r     <= 1'b0;
        end else begin
            comparator_result <= result_nxt; // [RULE10]
            result_prev_r     <= comparator_result;
        end
    end

    // ------------------------------------------------------------
    // hysteresis and node decode
    // ------------------------------------------------------------
    // feedback polarity depends on software setting inversion while masking
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ladder_node_effective <= '0;
        end else begin
            ladder_node_effective <= (ladder_node_select_r & ~hysteresis_mask_r) |
                                     ({CCH_NODE_W{comparator_result}} &
                                      hysteresis_mask_r); // [RULE8] [RULE9]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_node
            assign ladder_node_onehot[gi] = (ladder_node_effective == 5'(gi)); // [RULE4]
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt flag
    // ------------------------------------------------------------
    assign rise = comparator_result && !result_prev_r; // [RULE15] [RULE16]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            comparator_interrupt_flag_r <= 1'b0;
        end else if (rise) begin
            comparator_interrupt_flag_r <= 1'b1; // [RULE15] [RULE19]
        end else if (wr_stb && hit(wb_adr_i, CCH_IRQ_STATUS_OFS) &&
                     wb_dat_i[CCH_IRQ_BIT]) begin
            comparator_interrupt_flag_r <= 1'b0; // [RULE19]
        end
    end

    assign irq = comparator_interrupt_flag_r && irq_mask_r;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(wb_adr_i, CCH_MAIN_CTRL_OFS)) begin
            rd_word[7:0] = main_ctrl_r | ({7'h00, comparator_result} << CCH_MC_RESULT);
        end else if (hit(wb_adr_i, CCH_INPUT_SEL_OFS)) begin
            rd_word[7:0] = input_sel_r;
        end else if (hit(wb_adr_i, CCH_NODE_SEL_OFS)) begin
            rd_word[CCH_NODE_W-1:0] = ladder_node_select_r;
        end else if (hit(wb_adr_i, CCH_HYST_MASK_OFS)) begin
            rd_word[CCH_NODE_W-1:0] = hysteresis_mask_r;
        end else if (hit(wb_adr_i, CCH_IRQ_STATUS_OFS)) begin
            rd_word[CCH_IRQ_BIT] = comparator_interrupt_flag_r;
        end else if (hit(wb_adr_i, CCH_IRQ_MASK_OFS)) begin
            rd_word[CCH_IRQ_BIT] = irq_mask_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd_word;
        end
    end
endmodule
`default_nettype wire

/* File: src/cchyst_pkg.sv */
// package: register map, field layout and timing constants for the comparator control
package cchyst_pkg;
    // register offsets (byte addresses on the wishbone bus)
    localparam logic [7:0] CCH_MAIN_CTRL_OFS  = 8'h7A;
    localparam logic [7:0] CCH_INPUT_SEL_OFS  = 8'h7B;
    localparam logic [7:0] CCH_NODE_SEL_OFS   = 8'h7C;
    localparam logic [7:0] CCH_HYST_MASK_OFS  = 8'h7D;
    localparam logic [7:0] CCH_IRQ_STATUS_OFS = 8'h80;
    localparam logic [7:0] CCH_IRQ_MASK_OFS   = 8'h84;

    // main control fields
    localparam int CCH_MC_SRC_LSB   = 6;
    localparam int CCH_MC_RESULT    = 5;
    localparam int CCH_MC_SHORT     = 4;
    localparam int CCH_MC_INVERT    = 3;
    localparam int CCH_MC_FILTER    = 2;
    localparam int CCH_MC_SPEED     = 1;
    localparam int CCH_MC_ENABLE    = 0;

    // input and ladder select fields
    localparam int CCH_IS_GND_RET   = 7;
    localparam int CCH_IS_SHORT_HI  = 6;
    localparam int CCH_IS_SHORT_LO  = 5;
    localparam int CCH_IS_POS_LSB   = 2;
    localparam int CCH_IS_NEG_LSB   = 0;

    localparam int CCH_NODE_W       = 5;
    localparam int CCH_IRQ_BIT      = 0;

    // reset values
    localparam logic [7:0] CCH_MAIN_CTRL_RST = 8'h00;
    localparam logic [7:0] CCH_INPUT_SEL_RST = 8'h00;
    localparam logic [7:0] CCH_NODE_SEL_RST  = 8'h00;
    localparam logic [7:0] CCH_HYST_MASK_RST = 8'h00;

    // glitch filter timing
    localparam int CCH_CLK_MHZ       = 200;
    localparam int CCH_FILTER_NS     = 2000;
    localparam int CCH_FILTER_CYCLES = (CCH_FILTER_NS * CCH_CLK_MHZ + 999) / 1000;

    // input source codes
    localparam logic [1:0] CCH_IN_LVD   = 2'h0;
    localparam logic [1:0] CCH_IN_PB0   = 2'h1;
    localparam logic [1:0] CCH_IN_PB3   = 2'h2;
    localparam logic [1:0] CCH_IN_INT   = 2'h3;
endpackage

/* File: src/cchyst_sync.sv */
// two-flop synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
`default_nettype none
module cchyst_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: src/cchyst_filter.sv */
// glitch filter: output follows input only after it has held steady for hold cycles
`timescale 1ns/1ps
`default_nettype none
module cchyst_filter #(
    parameter int HOLD_CYCLES = cchyst_pkg::CCH_FILTER_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    import cchyst_pkg::*;

    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

    logic [CW-1:0] cnt_r;

    // a pulse shorter than the hold time restarts the count and never reaches dout
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= '0;
            dout  <= 1'b0;
        end else if (din == dout) begin
            cnt_r <= '0;
        end else if (cnt_r == HOLD_LAST) begin
            cnt_r <= '0;
            dout  <= din;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end
endmodule
`default_nettype wire

/* File: dv/cchyst_top_asserts.sv */
// checker: port-level assertions for the comparator control top
`timescale 1ns/1ps
`default_nettype none
module cchyst_top_asserts #(
    parameter int FILTER_CYCLES = 4
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        comparator_out_signal,
    input wire logic        comparator_enable,
    input wire logic        speed_mode_select,
    input wire logic        input_short_switch,
    input wire logic [1:0]  positive_input_select,
    input wire logic [1:0]  negative_input_select,
    input wire logic [1:0]  ladder_source_select,
    input wire logic [2:0]  ladder_low_section_control,
    input wire logic [31:0] ladder_node_onehot,
    input wire logic [4:0]  ladder_node_effective,
    input wire logic        comparator_result,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    logic        wr_q;
    logic [31:0] dat_q;
    assign wr_q = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
    always_ff @(posedge core_clk) begin
        dat_q <= wb_dat_i;
    end
    // ---------------------------------------------
    // properties
    // ---------------------------------------------
    AST_ACK_ONE: assert property (wb_cyc_i & wb_stb_i & ~wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_RD_UPPER: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_MAIN_WR: assert property (wr_q && wb_adr_i == 8'h7A |=>
        {ladder_source_select, input_short_switch, speed_mode_select, comparator_enable}
        == {dat_q[7:6], dat_q[4], dat_q[1], dat_q[0]})
        else $error("main control write not on outputs");
    AST_IN_WR: assert property (wr_q && wb_adr_i == 8'h7B |=>
        {ladder_low_section_control, positive_input_select, negative_input_select}
        == {dat_q[7:5], dat_q[3:0]})
        else $error("input select write not on outputs");
    AST_ONEHOT: assert property (ladder_node_onehot == 32'h1 << ladder_node_effective)
        else $error("node decode wrong");
    AST_EN_OFF: assert property (!comparator_enable |=> !comparator_result)
        else $error("result high while disabled");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(wb_we_i & wb_stb_i) ||
        ($past(comparator_result) && !$past(comparator_result, 2)))
        else $error("irq rose without a rising result");
    AST_RST_ZERO: assert property ($past(rst) |-> !comparator_enable && !irq &&
        ladder_source_select == 2'h0 && ladder_node_effective == 5'h00)
        else $error("outputs not cleared by reset");
endmodule
bind cchyst_top cchyst_top_asserts #(.FILTER_CYCLES(FILTER_CYCLES)) cchyst_top_asserts_i (
    .core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .comparator_out_signal, .comparator_enable, .speed_mode_select,
    .input_short_switch, .positive_input_select, .negative_input_select,
    .ladder_source_select, .ladder_low_section_control, .ladder_node_onehot,
    .ladder_node_effective, .comparator_result, .irq);
`default_nettype wire

/* File: dv/cchyst_analog_model.sv */
// behavioural analog front end: input muxes, short switch and comparison
`timescale 1ns/1ps
`default_nettype none
module cchyst_analog_model (
    input  wire logic [1:0]  positive_input_select,
    input  wire logic [1:0]  negative_input_select,
    input  wire logic        input_short_switch,
    input  wire logic [4:0]  ladder_node_effective,
    input  wire logic [15:0] lvd_mv,
    input  wire logic [15:0] pb0_mv,
    input  wire logic [15:0] pb3_mv,
    output logic             comparator_out_signal
);
    logic [15:0] vp;
    logic [15:0] vn;
    always_comb begin
        vp = (positive_input_select == 2'h0) ? lvd_mv :
             (positive_input_select == 2'h1) ? pb0_mv :
             (positive_input_select == 2'h2) ? pb3_mv : 16'h04B0;
        // ladder step of 50 mV is arbitrary
        vn = (negative_input_select == 2'h0) ? lvd_mv :
             (negative_input_select == 2'h1) ? pb0_mv :
             (negative_input_select == 2'h2) ? pb3_mv : 16'(ladder_node_effective) * 16'h0032;
        // shorted inputs compare equal, so the output settles low
        comparator_out_signal = !input_short_switch && (vp > vn);
    end
endmodule
`default_nettype wire

/* File: dv/cchyst_top_bench.sv */
// self-checking bench for the comparator control top
`timescale 1ns/1ps
`default_nettype none
module cchyst_top_bench;
    import cchyst_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [15:0] lvd_mv = 16'h01F4, pb0_mv = 16'h0000, pb3_mv = 16'h0000;
    logic        wb_ack_o, comparator_out_signal, comparator_enable, speed_mode_select;
    logic        input_short_switch, comparator_result, irq;
    logic [1:0]  positive_input_select, negative_input_select, ladder_source_select, c;
    logic [2:0]  ladder_low_section_control;
    logic [31:0] ladder_node_onehot;
    logic [4:0]  ladder_node_effective;
    int          num_errors = 0, samples_checked = 0;
    always #2.5 core_clk = ~core_clk;
    cchyst_top #(.FILTER_CYCLES(4)) cchyst_top_i (.core_clk, .rst, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .comparator_out_signal, .comparator_enable, .speed_mode_select, .input_short_switch,
        .positive_input_select, .negative_input_select, .ladder_source_select,
        .ladder_low_section_control, .ladder_node_onehot, .ladder_node_effective,
        .comparator_result, .irq);
    cchyst_analog_model cchyst_analog_model_i (.positive_input_select, .negative_input_select,
        .input_short_switch, .ladder_node_effective, .lvd_mv, .pb0_mv, .pb3_mv,
        .comparator_out_signal);
    // ---------------------------------------------
    // bus and check tasks
    // ---------------------------------------------
    task automatic finish_test();
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, 24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 40) chk(32'h0, 32'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 4'h1);
        chk(q, {24'h0, e});
    endtask
    // polls the settled result; bound covers sync plus filter hold
    task automatic wait_res(input logic v);
        int n;
        n = 0;
        while (comparator_result !== v && n < 30) begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(comparator_result), 32'(v));
    endtask
    // ---------------------------------------------
    // tests
    // ---------------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(CCH_MAIN_CTRL_OFS + 8'(i), 8'h00);
        wr(CCH_MAIN_CTRL_OFS, 8'hFE);
        rd(CCH_MAIN_CTRL_OFS, 8'hDE);
        chk(32'({ladder_source_select, input_short_switch, speed_mode_select}), 32'h0F);
        wr(CCH_INPUT_SEL_OFS, 8'hFF);
        rd(CCH_INPUT_SEL_OFS, 8'hEF);
        rd(CCH_MAIN_CTRL_OFS, 8'hDE);
        wr(CCH_NODE_SEL_OFS, 8'h15);
        wr(CCH_HYST_MASK_OFS, 8'h0A);
        wb(1'b1, CCH_NODE_SEL_OFS, 8'h00, 4'hE);
        rd(CCH_NODE_SEL_OFS, 8'h15);
        rd(CCH_HYST_MASK_OFS, 8'h0A);
        wr(8'h90, 8'hFF);
        rd(8'h90, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(CCH_MAIN_CTRL_OFS, {c, 6'h08});
            wr(CCH_INPUT_SEL_OFS, {c, c[1], 1'b0, c, ~c});
            chk(32'({ladder_source_select, ladder_low_section_control, positive_input_select,
                negative_input_select}), 32'({c, c, c[1], c, ~c}));
        end
        wr(CCH_HYST_MASK_OFS, 8'h00);
        wr(CCH_INPUT_SEL_OFS, 8'h04);
        wr(CCH_IRQ_MASK_OFS, 8'h01);
        wr(CCH_MAIN_CTRL_OFS, 8'h01);
        pb0_mv <= 16'h0384;
        wait_res(1'b1);
        rd(CCH_MAIN_CTRL_OFS, 8'h21);
        chk(32'(irq), 32'h1);
        rd(CCH_IRQ_STATUS_OFS, 8'h01);
        wr(CCH_IRQ_STATUS_OFS, 8'h01);
        repeat (8) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        pb0_mv <= 16'h0000;
        wait_res(1'b0);
        pb0_mv <= 16'h0384;
        wait_res(1'b1);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        wr(CCH_IRQ_MASK_OFS, 8'h00);
        chk(32'(irq), 32'h0);
        rd(CCH_IRQ_STATUS_OFS, 8'h01);
        wr(CCH_MAIN_CTRL_OFS, 8'h09);
        wr(CCH_HYST_MASK_OFS, 8'h0A);
        wait_res(1'b0);
        repeat (2) @(posedge core_clk);
        chk(32'(ladder_node_effective), 32'h15);
        pb0_mv <= 16'h0000;
        wait_res(1'b1);
        repeat (2) @(posedge core_clk);
        chk(32'(ladder_node_effective), 32'h1F);
        wr(CCH_MAIN_CTRL_OFS, 8'h08);
        wait_res(1'b0);
        wr(CCH_HYST_MASK_OFS, 8'h00);
        wr(CCH_MAIN_CTRL_OFS, 8'h07);
        chk(32'(speed_mode_select), 32'h1);
        pb0_mv <= 16'h0384;
        repeat (2) @(posedge core_clk);
        pb0_mv <= 16'h0000;
        repeat (15) @(posedge core_clk);
        chk(32'(comparator_result), 32'h0);
        pb0_mv <= 16'h0384;
        wait_res(1'b1);
        wr(CCH_MAIN_CTRL_OFS, 8'h05);
        chk(32'(speed_mode_select), 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
